//--- bench/cmoc_emitter.sv
// Infrared emitter model hanging on the output pin
`timescale 1ns/1ps
module cmoc_emitter (
	input  wire logic        clk_i,
	input  wire logic        pin_i,
	input  wire logic        pin_oe_i,
	output logic             lit_o,
	output logic [15:0]      pulses_o
);
	logic lit_q;
	// Driver input has a pull-down: a floating pin stays dark
	assign lit_o = pin_oe_i & pin_i;
	initial pulses_o = 16'h0;
	always @(posedge clk_i) begin
		if (lit_o && !lit_q)
			pulses_o <= pulses_o + 16'h1;
		lit_q <= lit_o;
	end
endmodule // cmoc_emitter

//--- bench/cmoc_properties.sv
// Port checker for the carrier modulator output control block
`timescale 1ns/1ps
module cmoc_properties (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        infrared_output_pin_o,
	input wire logic        infrared_output_pin_oe_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Reset checks fire on the first cycle after reset falls
	pin_reset_a: assert property (disable iff (1'b0) $fell(rst_i) |-> !infrared_output_pin_oe_o)
		else $error("pin enabled after reset");
	irq_reset_a: assert property (disable iff (1'b0) $fell(rst_i) |-> !irq_o && !wb_ack_o)
		else $error("irq or ack after reset");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	unmapped_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[5:2] > 4'hb |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	oe_cause_a: assert property ($changed(infrared_output_pin_oe_o) |->
		$past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2) || $past(wb_ack_o && wb_we_i, 3))
		else $error("pin enable changed without write");
	irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
		else $error("irq dropped without access");
endmodule // cmoc_properties

bind cmoc_top cmoc_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .infrared_output_pin_o, .infrared_output_pin_oe_o, .irq_o);

//--- bench/tb_carrier_modulator_output_control.sv
// Testbench for the carrier modulator output control block
`timescale 1ns/1ps
module tb_carrier_modulator_output_control;
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, ack, pin, oe, irq, lit;
	logic [5:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [7:0]  v;
	logic [31:0] wb_dat, dat_o, r;
	logic [15:0] pulses, p0;
	int          n_errors, tests_run, cyc_n, t0, t1, i, d;
	int          per[4];

	cmoc_top dut (.clk_i, .rst_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.infrared_output_pin_o(pin), .infrared_output_pin_oe_o(oe), .irq_o(irq));
	cmoc_emitter u_emit (.clk_i, .pin_i(pin), .pin_oe_i(oe), .lit_o(lit), .pulses_o(pulses));

	initial begin
		clk_i = 0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Generous ceiling: the prescale sweep needs a few thousand cycles
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wb(input logic we, input logic [5:0] a, input logic [7:0] dw);
		wb_cyc <= 1;
		wb_stb <= 1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= {24'h0, dw};
		do @(posedge clk_i); while (ack !== 1'b1);
		r = dat_o;
		wb_cyc <= 0;
		wb_stb <= 0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] dw);
		wb(1, a, dw);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		wb(0, a, 8'h0);
		chk(r, e);
	endtask

	// Status read then mark low access; wait out the irq latency
	task automatic clr();
		wb(0, 6'h04, 8'h0);
		wb(0, 6'h0c, 8'h0);
		repeat (3) @(posedge clk_i);
	endtask

	task automatic wait_irq(output int t);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 600) begin
			@(posedge clk_i);
			n++;
		end
		t = cyc_n;
		chk(irq, 1);
	endtask

	initial begin
		rst_i = 1;
		wb_cyc = 0;
		wb_stb = 0;
		wb_we = 0;
		wb_adr = 0;
		wb_sel = 4'h1;
		wb_dat = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		rd(6'h00, 0);
		rd(6'h04, 0);
		wr(6'h04, 8'hfe);
		rd(6'h04, 8'h7e);
		wr(6'h04, 8'h00);
		wr(6'h30, 8'h5a);
		rd(6'h30, 0);
		for (i = 0; i < 8; i++) begin
			v = {i[2:0], 5'h0};
			wr(6'h00, v);
			repeat (3) @(posedge clk_i);
			rd(6'h00, v);
			chk(oe, v[5]);
			chk(lit, v[5] & (v[6] ? v[7] : ~v[7]));
		end
		wr(6'h08, 8'h00);
		wr(6'h0c, 8'h40);
		wr(6'h10, 8'h00);
		wr(6'h14, 8'h20);
		wr(6'h18, 8'h02);
		wr(6'h1c, 8'h02);
		wr(6'h00, 8'h60);
		p0 = pulses;
		for (d = 0; d < 4; d++) begin
			// Stop write also zeroes prescale mid-cycle; new prescale set only once stopped
			wr(6'h04, 8'h02);
			repeat (400) @(posedge clk_i);
			clr();
			wr(6'h04, {1'b0, d[1:0], 5'h03});
			wait_irq(t0);
			clr();
			wait_irq(t0);
			clr();
			wait_irq(t1);
			per[d] = t1 - t0;
			chk(per[d], per[0] << d);
		end
		chk(pulses != p0, 1);
		wr(6'h04, 8'h02);
		repeat (400) @(posedge clk_i);
		clr();
		rd(6'h04, 8'h02);
		rd(6'h28, 1);
		chk(irq, 0);
		wr(6'h2c, 8'h01);
		repeat (3) @(posedge clk_i);
		chk(irq, 1);
		wr(6'h28, 8'h01);
		repeat (3) @(posedge clk_i);
		chk(irq, 0);
		rd(6'h28, 0);
		// Write without lane 0 must be ignored
		wb_sel <= 4'h0;
		wr(6'h2c, 8'h00);
		wb_sel <= 4'h1;
		rd(6'h2c, 1);
		// Unmodulated run: carrier held high, pin lit through mark
		wr(6'h04, 8'h09);
		repeat (20) @(posedge clk_i);
		chk(lit, 1);
		repeat (40) @(posedge clk_i);
		chk(lit, 1);
		wr(6'h04, 8'h00);
		report_and_stop();
	end
endmodule // tb_carrier_modulator_output_control

//--- hw/cmoc_cfg.svh
// Constants for the carrier modulator output control block
// Operation
// [RL1] Latch bit reads back; writes reach pin only when stopped and pin enabled.
// [RL2] Polarity bit 0 makes pin active low, 1 active high.
// [RL3] Enabled pin drives transmitter output when running, else latch, with polarity applied.
// [RL4] Pin is high impedance when disabled and held disabled during reset.
// [RL5] Cycle end flag sets when idle modulator is started by run enable.
// [RL6] At cycle end set flag, reload counter from mark, space from buffer.
// [RL7] Flag clears after status read followed by mark or space low byte access.
// [RL8] Re-enable before cycle end does not set flag; cycle end does.
// [RL9] Prescale code selects module clock as bus clock divided by 1, 2, 4, 8.
// [RL10] Software should not change prescale during a transmission.
// [RL11] Extended space bit enables extended space operation when one.
// [RL12] Unmodulated mode stops carrier generator and holds carrier output high.
// [RL13] Otherwise carrier toggles using carrier high and low times.
// [RL14] Unmodulated mode resets to zero; software should not write it mid-transmission.
// [RL15] Shift mode bit selects time or baseband at 0, shift keying at 1.
// [RL16] Interrupt requested while cycle end flag set and its enable is one.
// [RL17] Run enable starts all; clearing finishes cycle, stops clocks, forces output low.
// [RL18] Time mode uses primary pair; shift mode alternates primary and secondary.
`ifndef CMOC_CFG_SVH
`define CMOC_CFG_SVH

// ****************************************
// Register word indices (byte address bits 5:2)
// ****************************************
`define CMOC_ADR_OUTCTL   4'h0
`define CMOC_ADR_MODCTL   4'h1
`define CMOC_ADR_MARK_HI  4'h2
`define CMOC_ADR_MARK_LO  4'h3
`define CMOC_ADR_SPACE_HI 4'h4
`define CMOC_ADR_SPACE_LO 4'h5
`define CMOC_ADR_CAR_PH   4'h6
`define CMOC_ADR_CAR_PL   4'h7
`define CMOC_ADR_CAR_SH   4'h8
`define CMOC_ADR_CAR_SL   4'h9
`define CMOC_ADR_IRQ_ST   4'ha
`define CMOC_ADR_IRQ_MASK 4'hb

// ****************************************
// Field positions
// ****************************************
`define CMOC_OC_LATCH   7
`define CMOC_OC_POL     6
`define CMOC_OC_PINEN   5
`define CMOC_MS_CYCLE_END_FLAG    7
`define CMOC_MS_DIV_HI  6
`define CMOC_MS_DIV_LO  5
`define CMOC_MS_EXTENDED_SPACE_ENABLE   4
`define CMOC_MS_UNMODULATED_MODE_SELECT    3
`define CMOC_MS_FSK     2
`define CMOC_MS_CYCLE_END_IRQ_ENABLE   1
`define CMOC_MS_RUN     0

// ****************************************
// Reset values
// ****************************************
`define CMOC_RST_BYTE   8'h00
`define CMOC_RST_WORD   16'h0000

`endif

//--- hw/cmoc_pkg.sv
// Types for the carrier modulator output control block
package cmoc_pkg;

	typedef enum logic [1:0] {
		CMOC_IDLE  = 2'b00,
		CMOC_MARK  = 2'b01,
		CMOC_SPACE = 2'b10
	} cmoc_mod_t;

	typedef struct packed {
		logic [7:0]  outctl;
		logic        latch;
		logic        pol;
		logic        pinen;
		logic        cycle_end_flag;
		logic [1:0]  div;
		logic        extended_space_enable;
		logic        unmodulated_mode_select;
		logic        fsk;
		logic        cycle_end_irq_enable;
		logic        run;
		logic        status_read;
		logic [15:0] mark_buf;
		logic [15:0] space_buf;
		logic [15:0] space_reg;
		logic [15:0] count;
		logic [7:0]  car_ph;
		logic [7:0]  car_pl;
		logic [7:0]  car_sh;
		logic [7:0]  car_sl;
		logic [7:0]  car_cnt;
		logic        car_out;
		logic        use_sec;
		logic [2:0]  pre_cnt;
		cmoc_mod_t   mod;
		logic        irq_st;
		logic        irq_mask;
		logic        ack;
		logic [31:0] rdat;
		logic        pin;
		logic        pin_oe;
		logic        irq;
	} cmoc_state_t;

endpackage

//--- hw/cmoc_top.sv
// Carrier modulator output control with Wishbone register slave
`timescale 1ns/1ps
`include "cmoc_cfg.svh"

module cmoc_top
	import cmoc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             infrared_output_pin_o,
	output logic             infrared_output_pin_oe_o,
	output logic             irq_o
);

	cmoc_state_t s;
	cmoc_state_t next_s;

	logic        req;
	logic        wr;
	logic        rd;
	logic [3:0]  idx;
	logic        tick;
	logic        cyc_end;
	logic        car_reload;
	logic        mod_out;
	logic        tx_out;
	logic        drive;
	logic [7:0]  msc_rd;
	logic [2:0]  div_mask;

	// ****************************************
	// Bus decode
	// ****************************************
	always_comb begin
		req = wb_cyc_i && wb_stb_i && !s.ack;
		wr  = req && wb_we_i && wb_sel_i[0];
		rd  = req && !wb_we_i;
		idx = wb_adr_i[5:2];
	end

	// ****************************************
	// Prescaler and modulator timing
	// ****************************************
	always_comb begin
		case (s.div) // RL9
			2'b00:   div_mask = 3'h0;
			2'b01:   div_mask = 3'h1;
			2'b10:   div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
		// Division takes effect at once; no shadow copy
		tick = ((s.pre_cnt & div_mask) == div_mask); // RL9
		cyc_end = tick && (s.mod != CMOC_IDLE) && (s.count == s.space_reg); // RL6
		car_reload = tick && (s.car_cnt <= 8'h01);
		// Modulator gates the carrier during mark only
		mod_out = (s.mod == CMOC_MARK) && !(s.extended_space_enable && s.count != s.space_reg) && (s.unmodulated_mode_select || s.car_out);
		tx_out  = (s.mod == CMOC_IDLE) ? 1'b0 : mod_out; // RL17
		drive   = (s.mod != CMOC_IDLE) ? tx_out : s.latch; // RL3
		msc_rd  = {s.cycle_end_flag, s.div, s.extended_space_enable, s.unmodulated_mode_select, s.fsk, s.cycle_end_irq_enable, s.run};
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.ack = req;
		next_s.pre_cnt = s.pre_cnt + 3'h1;
		next_s.outctl = {s.latch, s.pol, s.pinen, 5'h00};

		// Read data
		next_s.rdat = 32'h0000_0000;
		case (idx)
			`CMOC_ADR_OUTCTL:   next_s.rdat[7:0] = {s.latch, s.pol, s.pinen, 5'h00}; // RL1
			`CMOC_ADR_MODCTL:   next_s.rdat[7:0] = msc_rd;
			`CMOC_ADR_MARK_HI:  next_s.rdat[7:0] = s.mark_buf[15:8];
			`CMOC_ADR_MARK_LO:  next_s.rdat[7:0] = s.mark_buf[7:0];
			`CMOC_ADR_SPACE_HI: next_s.rdat[7:0] = s.space_buf[15:8];
			`CMOC_ADR_SPACE_LO: next_s.rdat[7:0] = s.space_buf[7:0];
			`CMOC_ADR_CAR_PH:   next_s.rdat[7:0] = s.car_ph;
			`CMOC_ADR_CAR_PL:   next_s.rdat[7:0] = s.car_pl;
			`CMOC_ADR_CAR_SH:   next_s.rdat[7:0] = s.car_sh;
			`CMOC_ADR_CAR_SL:   next_s.rdat[7:0] = s.car_sl;
			`CMOC_ADR_IRQ_ST:   next_s.rdat[0]   = s.irq_st;
			`CMOC_ADR_IRQ_MASK: next_s.rdat[0]   = s.irq_mask;
			default:            next_s.rdat = 32'h0000_0000;
		endcase
		if (!rd)
			next_s.rdat = s.rdat;

		// Flag clear: status read arms, low byte access completes
		if (req && (idx == `CMOC_ADR_MARK_LO || idx == `CMOC_ADR_SPACE_LO) && s.status_read) begin
			next_s.cycle_end_flag = 1'b0; // RL7
			next_s.status_read = 1'b0;
		end
		if (rd && idx == `CMOC_ADR_MODCTL && s.cycle_end_flag)
			next_s.status_read = 1'b1; // RL7

		// Register writes
		if (wr) begin
			case (idx)
				`CMOC_ADR_OUTCTL: begin
					next_s.latch = wb_dat_i[`CMOC_OC_LATCH]; // RL1
					next_s.pol   = wb_dat_i[`CMOC_OC_POL]; // RL2
					next_s.pinen = wb_dat_i[`CMOC_OC_PINEN]; // RL4
				end
				`CMOC_ADR_MODCTL: begin
					next_s.div   = wb_dat_i[`CMOC_MS_DIV_HI:`CMOC_MS_DIV_LO];
					next_s.extended_space_enable = wb_dat_i[`CMOC_MS_EXTENDED_SPACE_ENABLE]; // RL11
					next_s.unmodulated_mode_select  = wb_dat_i[`CMOC_MS_UNMODULATED_MODE_SELECT]; // RL14
					next_s.fsk   = wb_dat_i[`CMOC_MS_FSK]; // RL15
					next_s.cycle_end_irq_enable = wb_dat_i[`CMOC_MS_CYCLE_END_IRQ_ENABLE];
					next_s.run   = wb_dat_i[`CMOC_MS_RUN];
				end
				`CMOC_ADR_MARK_HI:  next_s.mark_buf[15:8]  = wb_dat_i[7:0];
				`CMOC_ADR_MARK_LO:  next_s.mark_buf[7:0]   = wb_dat_i[7:0];
				`CMOC_ADR_SPACE_HI: next_s.space_buf[15:8] = wb_dat_i[7:0];
				`CMOC_ADR_SPACE_LO: next_s.space_buf[7:0]  = wb_dat_i[7:0];
				`CMOC_ADR_CAR_PH:   next_s.car_ph = wb_dat_i[7:0];
				`CMOC_ADR_CAR_PL:   next_s.car_pl = wb_dat_i[7:0];
				`CMOC_ADR_CAR_SH:   next_s.car_sh = wb_dat_i[7:0];
				`CMOC_ADR_CAR_SL:   next_s.car_sl = wb_dat_i[7:0];
				`CMOC_ADR_IRQ_ST: begin
					if (wb_dat_i[0])
						next_s.irq_st = 1'b0;
				end
				`CMOC_ADR_IRQ_MASK: next_s.irq_mask = wb_dat_i[0];
				default: next_s.irq_mask = s.irq_mask;
			endcase
		end

		// Start from idle sets the flag; restart mid-cycle does not.
		// No edge on run needed: a run set in the cycle that ended
		// the last transmission must still start the next one.
		if (s.mod == CMOC_IDLE && next_s.run) begin
			next_s.mod     = CMOC_MARK; // RL17
			next_s.count   = s.mark_buf;
			next_s.space_reg = s.space_buf;
			next_s.car_cnt = s.car_ph;
			next_s.car_out = 1'b1;
			next_s.use_sec = 1'b0;
			next_s.cycle_end_flag    = 1'b1; // RL5
		end else if (cyc_end) begin
			next_s.cycle_end_flag = 1'b1; // RL6 RL8
			if (s.run) begin
				next_s.mod       = CMOC_MARK;
				next_s.count     = s.mark_buf; // RL6
				next_s.space_reg = s.space_buf; // RL6
				if (s.fsk)
					next_s.use_sec = !s.use_sec; // RL18
			end else begin
				next_s.mod = CMOC_IDLE; // RL17
			end
		end else if (tick && s.mod != CMOC_IDLE) begin
			next_s.count = s.count - 16'h0001;
			if (s.count == 16'h0000 || s.count <= s.space_reg)
				next_s.mod = CMOC_SPACE;
		end

		// Carrier generator
		if (s.unmodulated_mode_select) begin
			next_s.car_out = 1'b1; // RL12
		end else if (s.mod != CMOC_IDLE && tick) begin
			if (car_reload) begin
				next_s.car_out = !s.car_out; // RL13
				if (s.car_out)
					next_s.car_cnt = (s.fsk && s.use_sec) ? s.car_sl : s.car_pl; // RL18
				else
					next_s.car_cnt = (s.fsk && s.use_sec) ? s.car_sh : s.car_ph; // RL18
			end else begin
				next_s.car_cnt = s.car_cnt - 8'h01;
			end
		end

		// Set wins over clear for the sticky status
		if (next_s.cycle_end_flag && !s.cycle_end_flag)
			next_s.irq_st = 1'b1;

		// Pin drive
		next_s.pin_oe = s.pinen; // RL4
		next_s.pin    = s.pol ? drive : !drive; // RL2 RL3
		next_s.irq    = (s.cycle_end_flag && s.cycle_end_irq_enable) || (s.irq_st && s.irq_mask); // RL16
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0; // RL4 RL14
		end else begin
			s <= next_s;
		end
	end

	assign wb_dat_o                 = s.rdat;
	assign wb_ack_o                 = s.ack;
	assign infrared_output_pin_o    = s.pin;
	assign infrared_output_pin_oe_o = s.pin_oe;
	assign irq_o                    = s.irq;

endmodule // cmoc_top
